//--- include/pifrs_pkg.sv
// package for the peripheral interrupt flag and reset status bank
// assumes an 8-bit data space with byte-wide registers
package pifrs_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // data-space register addresses
    localparam logic [ADDR_W-1:0] ADDR_CORE_IRQ_CTRL = 8'h0b;
    localparam logic [ADDR_W-1:0] ADDR_PERIPH_FLAGS  = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_NVM_FLAG      = 8'h0d;
    localparam logic [ADDR_W-1:0] ADDR_PERIPH_ENABLE = 8'h8c;
    localparam logic [ADDR_W-1:0] ADDR_NVM_ENABLE    = 8'h8d;
    localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE   = 8'h8e;
    // an enable register maps onto its flag register by dropping the bank bit
    localparam logic [ADDR_W-1:0] ENABLE_TO_FLAG_MASK = 8'h7f;

    // bit positions
    localparam int unsigned BIT_PARALLEL = 7;
    localparam int unsigned BIT_CONV     = 6;
    localparam int unsigned BIT_RX       = 5;
    localparam int unsigned BIT_TX       = 4;
    localparam int unsigned BIT_CCP      = 2;
    localparam int unsigned BIT_PERIOD   = 1;
    localparam int unsigned BIT_OVF      = 0;
    localparam int unsigned BIT_NVM      = 4;
    localparam int unsigned BIT_POR      = 1;
    localparam int unsigned BIT_BROWNOUT = 0;
    localparam int unsigned BIT_GLOBAL   = 7;
    localparam int unsigned BIT_PERIPH   = 6;

    // implemented-bit masks
    localparam logic [DATA_W-1:0] PERIPH_FLAG_RW_MASK = 8'hc7;
    localparam logic [DATA_W-1:0] PERIPH_ENABLE_MASK  = 8'hf7;
    localparam logic [DATA_W-1:0] NVM_MASK            = 8'h10;
    localparam logic [DATA_W-1:0] RESET_CAUSE_MASK    = 8'h03;
    localparam logic [DATA_W-1:0] CORE_IRQ_MASK       = 8'hc0;
    localparam logic [DATA_W-1:0] PARALLEL_KEEP_MASK  = 8'h7f;

    // reset values
    localparam logic [DATA_W-1:0] REG_RST         = 8'h00;
    localparam logic [DATA_W-1:0] RESET_CAUSE_RST = 8'h01;
    localparam logic [DATA_W-1:0] RESET_CAUSE_ARM = 8'h03;

    // controller software registers
    localparam int unsigned        SW_ADDR_W       = 3;
    localparam logic [SW_ADDR_W-1:0] SW_REG_TARGET = 3'h0;
    localparam logic [SW_ADDR_W-1:0] SW_REG_DATA   = 3'h1;
    localparam logic [SW_ADDR_W-1:0] SW_REG_CTRL   = 3'h2;
    localparam logic [SW_ADDR_W-1:0] SW_REG_STATUS = 3'h3;
    localparam logic [SW_ADDR_W-1:0] SW_REG_RESULT = 3'h4;
    localparam logic [SW_ADDR_W-1:0] SW_REG_CAUSE  = 3'h5;
    localparam logic [SW_ADDR_W-1:0] SW_REG_CFG    = 3'h6;
    localparam int unsigned CTRL_WRITE  = 0;
    localparam int unsigned CTRL_READ   = 1;
    localparam int unsigned CTRL_ENABLE = 2;
    localparam int unsigned STAT_BUSY   = 0;
    localparam int unsigned STAT_IRQ    = 1;
    localparam int unsigned CFG_HAS_PARALLEL = 0;

    typedef enum logic [1:0] {
        CCP_OFF,
        CCP_CAPTURE,
        CCP_COMPARE,
        CCP_PWM
    } pifrs_ccp_mode_t;

endpackage

//--- include/pifrs_if.sv
// carrier between the register bank and its core/peripheral side
// assumes one common clock; no clocking block
`timescale 1ns/10ps
`default_nettype none
interface pifrs_if;
    import pifrs_pkg::*;

    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              evt_parallel;
    logic              evt_conv_done;
    logic              rx_buf_full;
    logic              tx_buf_empty;
    logic              evt_capture;
    logic              evt_compare;
    pifrs_ccp_mode_t   ccp_mode;
    logic              evt_period_match;
    logic              evt_wide_overflow;
    logic              evt_nvm_done;
    logic              evt_brownout;
    logic              irq_req;

    modport dev (
        input  addr, wr, rd, wdata, evt_parallel, evt_conv_done, rx_buf_full, tx_buf_empty,
               evt_capture, evt_compare, ccp_mode, evt_period_match, evt_wide_overflow,
               evt_nvm_done, evt_brownout,
        output rdata, irq_req
    );

    modport host (
        output addr, wr, rd, wdata, evt_parallel, evt_conv_done, rx_buf_full, tx_buf_empty,
               evt_capture, evt_compare, ccp_mode, evt_period_match, evt_wide_overflow,
               evt_nvm_done, evt_brownout,
        input  rdata, irq_req
    );
endinterface
`default_nettype wire

//--- rtl/pifrs_flag_cell.sv
// one sticky interrupt flag bit
// assumes set, write strobe and data all on the same clock
`timescale 1ns/10ps
`default_nettype none
module pifrs_flag_cell (
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    input  wire logic set_i,
    input  wire logic wr_i,
    input  wire logic wdata_i,
    output var  logic flag_o
);
    logic flag_d;

    always_comb begin
        flag_d = flag_o;
        if (wr_i) begin
            flag_d = wdata_i;
        end
        if (set_i) begin
            flag_d = 1'b1;               // event beats a clear
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= flag_d;
        end
    end
endmodule // pifrs_flag_cell

//--- rtl/pifrs_dev.sv
// register bank: peripheral flags, enables, core irq gating, reset cause
// assumes rst_b_i is the power-on reset; other resets arrive as events
//
// Overview of operation
// - flags latch regardless of any enable
// - software clears flag before enabling it
// - parallel-port flag bit 7, software cleared
// - conversion-done flag bit 6
// - read-only bit 5 follows receive buffer
// - read-only bit 4 follows transmit buffer
// - capture sets bit 2, software cleared
// - compare sets bit 2; PWM unused
// - bit 1 sets on period match
// - bit 0 sets on wide-timer overflow
// - unimplemented bits ignore writes, read zero
// - software keeps parallel flag zero without port
// - second enable: bit 4 only
// - write-complete flag bit 4, software cleared
// - power-on clears bit 1; software sets
// - brown-out clears bit 0; software sets
// - brown-out bit meaningless when detector off
// - per-flag enables gate each request
// - peripheral enable gates all peripheral requests
// - global enable gates every request
`timescale 1ns/10ps
`default_nettype none
module pifrs_dev
    import pifrs_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rst_b_i,
    pifrs_if.dev      bus,
    input  wire logic brownout_detector_enable_i,
    output var  logic irq_request_o
);
    logic [DATA_W-1:0] core_irq_q;
    logic [DATA_W-1:0] periph_enable_q;
    logic [DATA_W-1:0] nvm_enable_q;
    logic [DATA_W-1:0] reset_cause_q;
    logic [DATA_W-1:0] reset_cause_d;
    logic [DATA_W-1:0] flag_set;
    logic [DATA_W-1:0] flag_q;
    logic [DATA_W-1:0] periph_flags_rd;
    logic              nvm_flag_q;
    logic [DATA_W-1:0] nvm_flag_rd;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic              irq_q;
    logic              ccp_set;
    logic              wr_flags;
    logic              wr_nvm_flag;
    logic              periph_pending;

    assign wr_flags    = bus.wr && (bus.addr == ADDR_PERIPH_FLAGS);
    assign wr_nvm_flag = bus.wr && (bus.addr == ADDR_NVM_FLAG);

    // capture/compare source depends on the unit's mode
    always_comb begin
        ccp_set = 1'b0;
        case (bus.ccp_mode)
            CCP_CAPTURE: ccp_set = bus.evt_capture;
            CCP_COMPARE: ccp_set = bus.evt_compare;
            CCP_PWM:     ccp_set = 1'b0;
            default:     ccp_set = 1'b0;
        endcase
    end

    always_comb begin
        flag_set               = REG_RST;
        flag_set[BIT_PARALLEL] = bus.evt_parallel;
        flag_set[BIT_CONV]     = bus.evt_conv_done;
        flag_set[BIT_CCP]      = ccp_set;
        flag_set[BIT_PERIOD]   = bus.evt_period_match;
        flag_set[BIT_OVF]      = bus.evt_wide_overflow;
    end

    // sticky cells only where the bit is writable; the rest stay zero
    for (genvar i = 0; i < DATA_W; i++) begin : g_flag
        if (PERIPH_FLAG_RW_MASK[i]) begin : g_cell
            pifrs_flag_cell u_cell (
                .ref_clk_i (ref_clk_i),
                .rst_b_i   (rst_b_i),
                .set_i     (flag_set[i]),
                .wr_i      (wr_flags),
                .wdata_i   (bus.wdata[i]),
                .flag_o    (flag_q[i])
            );
        end else begin : g_none
            assign flag_q[i] = 1'b0;
        end
    end

    pifrs_flag_cell u_nvm_flag (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .set_i     (bus.evt_nvm_done),
        .wr_i      (wr_nvm_flag),
        .wdata_i   (bus.wdata[BIT_NVM]),
        .flag_o    (nvm_flag_q)
    );

    // buffer state bits are live, so writes cannot touch them
    always_comb begin
        periph_flags_rd         = flag_q;
        periph_flags_rd[BIT_RX] = bus.rx_buf_full;
        periph_flags_rd[BIT_TX] = bus.tx_buf_empty;
        nvm_flag_rd             = REG_RST;
        nvm_flag_rd[BIT_NVM]    = nvm_flag_q;
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_irq_q <= REG_RST;
        end else if (bus.wr && bus.addr == ADDR_CORE_IRQ_CTRL) begin
            core_irq_q <= bus.wdata & CORE_IRQ_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            periph_enable_q <= REG_RST;
        end else if (bus.wr && bus.addr == ADDR_PERIPH_ENABLE) begin
            periph_enable_q <= bus.wdata & PERIPH_ENABLE_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nvm_enable_q <= REG_RST;
        end else if (bus.wr && bus.addr == ADDR_NVM_ENABLE) begin
            nvm_enable_q <= bus.wdata & NVM_MASK;
        end
    end

    // power-on status only falls under the power-on reset itself;
    // a brown-out with the detector off leaves the bit as it was,
    // which is why software must not trust it then
    always_comb begin
        reset_cause_d = reset_cause_q;
        if (bus.wr && bus.addr == ADDR_RESET_CAUSE) begin
            reset_cause_d = bus.wdata & RESET_CAUSE_MASK;
        end
        if (bus.evt_brownout && brownout_detector_enable_i) begin
            reset_cause_d[BIT_BROWNOUT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reset_cause_q <= RESET_CAUSE_RST;
        end else begin
            reset_cause_q <= reset_cause_d;
        end
    end

    // read data is registered: it stands the cycle after the strobe
    always_comb begin
        rdata_d = REG_RST;
        case (bus.addr)
            ADDR_CORE_IRQ_CTRL: rdata_d = core_irq_q;
            ADDR_PERIPH_FLAGS:  rdata_d = periph_flags_rd;
            ADDR_NVM_FLAG:      rdata_d = nvm_flag_rd;
            ADDR_PERIPH_ENABLE: rdata_d = periph_enable_q;
            ADDR_NVM_ENABLE:    rdata_d = nvm_enable_q;
            ADDR_RESET_CAUSE:   rdata_d = reset_cause_q;
            default:            rdata_d = REG_RST;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= REG_RST;
        end else if (bus.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= REG_RST;
        end
    end

    assign periph_pending = |(periph_flags_rd & periph_enable_q)
                          | |(nvm_flag_rd & nvm_enable_q);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= core_irq_q[BIT_GLOBAL]
                   && core_irq_q[BIT_PERIPH]
                   && periph_pending;
        end
    end

    assign bus.rdata     = rdata_q;
    assign bus.irq_req   = irq_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_request_o <= 1'b0;
        end else begin
            irq_request_o <= irq_q;
        end
    end
endmodule // pifrs_dev
`default_nettype wire

//--- rtl/pifrs_host.sv
// core/peripheral side: drives the bank's data-space port and events
// assumes software on sw_* and peripheral events on the same clock
`timescale 1ns/10ps
`default_nettype none
module pifrs_host
    import pifrs_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    pifrs_if.host                  bus,
    input  wire logic [SW_ADDR_W-1:0] sw_addr_i,
    input  wire logic [DATA_W-1:0] sw_wdata_i,
    input  wire logic              sw_wr_i,
    input  wire logic              sw_rd_i,
    output var  logic [DATA_W-1:0] sw_rdata_o,
    input  wire logic              evt_parallel_i,
    input  wire logic              evt_conv_done_i,
    input  wire logic              rx_buf_full_i,
    input  wire logic              tx_buf_empty_i,
    input  wire logic              evt_capture_i,
    input  wire logic              evt_compare_i,
    input  wire pifrs_ccp_mode_t   ccp_mode_i,
    input  wire logic              evt_period_match_i,
    input  wire logic              evt_wide_overflow_i,
    input  wire logic              evt_nvm_done_i,
    input  wire logic              evt_brownout_i,
    output var  logic              irq_o
);
    typedef enum logic [3:0] {
        H_BOOT, H_BOOT_RDA, H_BOOT_RDB, H_IDLE,
        H_RDA, H_RDB, H_EN_RDA, H_EN_RDB, H_EN_SET
    } pifrs_host_state_t;

    pifrs_host_state_t state_q;
    logic [ADDR_W-1:0] target_q;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] result_q;
    logic [DATA_W-1:0] cause_q;
    logic              has_parallel_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic              wr_q;
    logic              rd_q;
    logic [DATA_W-1:0] data_safe;
    logic              ctrl_wr;

    assign ctrl_wr = sw_wr_i && (sw_addr_i == SW_REG_CTRL);

    // without the parallel port its flag and enable are reserved
    always_comb begin
        data_safe = data_q;
        if (!has_parallel_q && ((target_q & ENABLE_TO_FLAG_MASK) == ADDR_PERIPH_FLAGS)) begin
            data_safe = data_q & PARALLEL_KEEP_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            target_q       <= REG_RST;
            data_q         <= REG_RST;
            has_parallel_q <= 1'b0;
        end else if (sw_wr_i) begin
            if (sw_addr_i == SW_REG_TARGET) begin
                target_q <= sw_wdata_i;
            end
            if (sw_addr_i == SW_REG_DATA) begin
                data_q <= sw_wdata_i;
            end
            if (sw_addr_i == SW_REG_CFG) begin
                has_parallel_q <= sw_wdata_i[CFG_HAS_PARALLEL];
            end
        end
    end

    // boot reads the reset cause before re-arming it, so the cause survives
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q  <= H_BOOT;
            addr_q   <= REG_RST;
            wdata_q  <= REG_RST;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            result_q <= REG_RST;
            cause_q  <= REG_RST;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            case (state_q)
                H_BOOT: begin
                    addr_q  <= ADDR_RESET_CAUSE;
                    rd_q    <= 1'b1;
                    state_q <= H_BOOT_RDA;
                end
                H_BOOT_RDA: state_q <= H_BOOT_RDB;
                H_BOOT_RDB: begin
                    cause_q <= bus.rdata;
                    wdata_q <= RESET_CAUSE_ARM;
                    wr_q    <= 1'b1;
                    state_q <= H_IDLE;
                end
                H_IDLE: begin
                    if (ctrl_wr && sw_wdata_i[CTRL_WRITE]) begin
                        addr_q  <= target_q;
                        wdata_q <= data_safe;
                        wr_q    <= 1'b1;
                    end else if (ctrl_wr && sw_wdata_i[CTRL_READ]) begin
                        addr_q  <= target_q;
                        rd_q    <= 1'b1;
                        state_q <= H_RDA;
                    end else if (ctrl_wr && sw_wdata_i[CTRL_ENABLE]) begin
                        addr_q  <= target_q & ENABLE_TO_FLAG_MASK;
                        rd_q    <= 1'b1;
                        state_q <= H_EN_RDA;
                    end
                end
                H_RDA:    state_q <= H_RDB;
                H_RDB: begin
                    result_q <= bus.rdata;
                    state_q  <= H_IDLE;
                end
                H_EN_RDA: state_q <= H_EN_RDB;
                H_EN_RDB: begin
                    wdata_q <= bus.rdata & ~data_q;           // stale flags cleared first
                    wr_q    <= 1'b1;
                    state_q <= H_EN_SET;
                end
                H_EN_SET: begin
                    addr_q  <= target_q;
                    wdata_q <= data_safe;
                    wr_q    <= 1'b1;
                    state_q <= H_IDLE;
                end
                default:  state_q <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_rdata_o <= REG_RST;
        end else if (sw_rd_i) begin
            case (sw_addr_i)
                SW_REG_TARGET: sw_rdata_o <= target_q;
                SW_REG_DATA:   sw_rdata_o <= data_q;
                SW_REG_STATUS: sw_rdata_o <= {{(DATA_W-2){1'b0}}, bus.irq_req, state_q != H_IDLE};
                SW_REG_RESULT: sw_rdata_o <= result_q;
                SW_REG_CAUSE:  sw_rdata_o <= cause_q;
                SW_REG_CFG:    sw_rdata_o <= {{(DATA_W-1){1'b0}}, has_parallel_q};
                default:       sw_rdata_o <= REG_RST;
            endcase
        end else begin
            sw_rdata_o <= REG_RST;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= bus.irq_req;
        end
    end

    assign bus.addr              = addr_q;
    assign bus.wr                = wr_q;
    assign bus.rd                = rd_q;
    assign bus.wdata             = wdata_q;
    assign bus.evt_parallel      = evt_parallel_i;
    assign bus.evt_conv_done     = evt_conv_done_i;
    assign bus.rx_buf_full       = rx_buf_full_i;
    assign bus.tx_buf_empty      = tx_buf_empty_i;
    assign bus.evt_capture       = evt_capture_i;
    assign bus.evt_compare       = evt_compare_i;
    assign bus.ccp_mode          = ccp_mode_i;
    assign bus.evt_period_match  = evt_period_match_i;
    assign bus.evt_wide_overflow = evt_wide_overflow_i;
    assign bus.evt_nvm_done      = evt_nvm_done_i;
    assign bus.evt_brownout      = evt_brownout_i;
endmodule // pifrs_host
`default_nettype wire

//--- test/pifrs_checker.sv
// assertions on the data-space port between the two ends
// assumes one clock; instantiated beside the interface, no bind
`timescale 1ns/10ps
`default_nettype none
module pifrs_checker
    import pifrs_pkg::*;
(
    input wire logic              ref_clk_i,
    input wire logic              rst_b_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_i,
    input wire logic              rx_buf_full_i,
    input wire logic              tx_buf_empty_i,
    input wire logic              evt_conv_done_i,
    input wire logic              evt_period_match_i,
    input wire logic              evt_wide_overflow_i,
    input wire logic              evt_nvm_done_i
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic rd_flags = rd_i && addr_i == ADDR_PERIPH_FLAGS;

    a_strobe_excl: assert property (!(wr_i && rd_i))
        else $error("read and write strobes high together");
    a_rdata_idle: assert property (!rd_i |=> rdata_i == 8'h00)
        else $error("read data outside its cycle");
    a_rx_live: assert property (rd_flags |=> rdata_i[BIT_RX] == $past(rx_buf_full_i))
        else $error("receive bit does not follow buffer");
    a_tx_live: assert property (rd_flags |=> rdata_i[BIT_TX] == $past(tx_buf_empty_i))
        else $error("transmit bit does not follow buffer");
    a_flag_gap: assert property (rd_flags |=> rdata_i[3] == 1'b0)
        else $error("unimplemented flag bit reads one");
    // a latched flag is lost only to a write
    a_conv_sets: assert property (evt_conv_done_i ##1 (!wr_i)[*6] ##1 rd_flags |=> rdata_i[BIT_CONV])
        else $error("conversion flag missed");
    a_period_sets: assert property (evt_period_match_i ##1 (!wr_i)[*6] ##1 rd_flags |=> rdata_i[BIT_PERIOD])
        else $error("period match flag missed");
    a_ovf_sets: assert property (evt_wide_overflow_i ##1 (!wr_i)[*6] ##1 rd_flags |=> rdata_i[BIT_OVF])
        else $error("overflow flag missed");
    a_nvm_sets: assert property (evt_nvm_done_i ##1 (!wr_i)[*6] ##1 (rd_i && addr_i == ADDR_NVM_FLAG)
            |=> rdata_i == NVM_MASK)
        else $error("write-complete flag wrong");
    a_nvm_bits: assert property (rd_i && addr_i == ADDR_NVM_ENABLE |=> (rdata_i & ~NVM_MASK) == 8'h00)
        else $error("second enable register has extra bits");
    a_cause_bits: assert property (rd_i && addr_i == ADDR_RESET_CAUSE |=> rdata_i[7:2] == 6'h00)
        else $error("reset cause upper bits nonzero");
endmodule // pifrs_checker
`default_nettype wire

//--- test/tb_peripheral_irq_flags_reset_status.sv
// self-checking bench: host end drives the bank end over the interface
// assumes software reaches the bank only through the host's register port
`timescale 1ns/10ps
`default_nettype none
module tb_peripheral_irq_flags_reset_status;
    import pifrs_pkg::*;
    logic                 ref_clk  = 1'b0;
    logic                 rst_b    = 1'b0;
    logic [SW_ADDR_W-1:0] sw_addr  = '0;
    logic [DATA_W-1:0]    sw_wdata = '0;
    logic                 sw_wr    = 1'b0;
    logic                 sw_rd    = 1'b0;
    logic                 rx       = 1'b0;
    logic                 tx       = 1'b1;
    logic                 bo_en    = 1'b1;
    logic [7:0]           evt      = '0; // par conv cap cmp per ovf nvm brown
    pifrs_ccp_mode_t      ccp      = CCP_CAPTURE;
    logic [DATA_W-1:0]    sw_rdata;
    logic [DATA_W-1:0]    rv;
    logic                 irq;
    logic                 irq_dev;
    int                   mismatches = 0;
    int                   n_tests    = 0;
    int                   cyc        = 0;

    always #12.5 ref_clk = ~ref_clk;
    pifrs_if bus_if ();
    pifrs_dev i_pifrs_dev (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .bus(bus_if.dev),
        .brownout_detector_enable_i(bo_en), .irq_request_o(irq_dev));
    pifrs_host i_pifrs_host (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .bus(bus_if.host), .sw_addr_i(sw_addr),
        .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
        .evt_parallel_i(evt[0]), .evt_conv_done_i(evt[1]), .rx_buf_full_i(rx), .tx_buf_empty_i(tx),
        .evt_capture_i(evt[2]), .evt_compare_i(evt[3]), .ccp_mode_i(ccp), .evt_period_match_i(evt[4]),
        .evt_wide_overflow_i(evt[5]), .evt_nvm_done_i(evt[6]), .evt_brownout_i(evt[7]), .irq_o(irq));
    pifrs_checker i_pifrs_checker (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .addr_i(bus_if.addr), .wr_i(bus_if.wr),
        .rd_i(bus_if.rd), .rdata_i(bus_if.rdata), .rx_buf_full_i(bus_if.rx_buf_full),
        .tx_buf_empty_i(bus_if.tx_buf_empty), .evt_conv_done_i(bus_if.evt_conv_done),
        .evt_period_match_i(bus_if.evt_period_match), .evt_wide_overflow_i(bus_if.evt_wide_overflow),
        .evt_nvm_done_i(bus_if.evt_nvm_done));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sw_w(input logic [SW_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_r(input logic [SW_ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    // fixed wait: the longest host operation is done four cycles after its order
    task automatic dev_op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
        sw_w(SW_REG_TARGET, a);
        sw_w(SW_REG_DATA, d);
        sw_w(SW_REG_CTRL, c);
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task automatic rdf(input logic [7:0] a, input logic [7:0] e);
        dev_op(a, 8'h00, 8'h02);
        sw_r(SW_REG_RESULT, rv);
        chk(rv, e);
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge ref_clk);
        evt <= v;
        @(posedge ref_clk);
        evt <= 8'h00;
    endtask

    task automatic t_boot();
        sw_r(SW_REG_CAUSE, rv);
        chk(rv, 8'h01);
        rdf(ADDR_RESET_CAUSE, 8'h03);
        rdf(8'h20, 8'h00);
        rdf(ADDR_PERIPH_FLAGS, 8'h10);
        dev_op(ADDR_NVM_ENABLE, 8'hff, 8'h01);
        rdf(ADDR_NVM_ENABLE, 8'h10);
        dev_op(ADDR_NVM_ENABLE, 8'h00, 8'h01);
        $display("boot test done");
    endtask
    task automatic t_flags();
        sw_w(SW_REG_CFG, 8'h01);
        pulse(8'h77);
        rdf(ADDR_PERIPH_FLAGS, 8'hd7);
        pulse(8'h40);
        rdf(ADDR_NVM_FLAG, 8'h10);
        chk(irq, 1'b0);
        dev_op(ADDR_PERIPH_FLAGS, 8'h00, 8'h01);
        rdf(ADDR_PERIPH_FLAGS, 8'h10);
        dev_op(ADDR_PERIPH_FLAGS, 8'hff, 8'h01);
        rdf(ADDR_PERIPH_FLAGS, 8'hd7);
        dev_op(ADDR_PERIPH_FLAGS, 8'h00, 8'h01);
        dev_op(ADDR_NVM_FLAG, 8'h00, 8'h01);
        rdf(ADDR_NVM_FLAG, 8'h00);
        $display("flag test done");
    endtask
    task automatic t_ccp();
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 2; k++) begin
                @(posedge ref_clk);
                ccp <= pifrs_ccp_mode_t'(m);
                pulse(k == 1 ? 8'h08 : 8'h04);
                rdf(ADDR_PERIPH_FLAGS, (m == k + 1) ? 8'h14 : 8'h10);
                dev_op(ADDR_PERIPH_FLAGS, 8'h00, 8'h01);
            end
        end
        $display("capture/compare test done");
    endtask
    task automatic t_live();
        @(posedge ref_clk);
        rx <= 1'b1;
        tx <= 1'b0;
        rdf(ADDR_PERIPH_FLAGS, 8'h20);
        dev_op(ADDR_PERIPH_FLAGS, 8'h00, 8'h01);
        rdf(ADDR_PERIPH_FLAGS, 8'h20);
        @(posedge ref_clk);
        rx <= 1'b0;
        tx <= 1'b1;
        $display("buffer state test done");
    endtask
    task automatic t_irq();
        pulse(8'h10);
        dev_op(ADDR_PERIPH_ENABLE, 8'h02, 8'h04);
        rdf(ADDR_PERIPH_FLAGS, 8'h10);
        rdf(ADDR_PERIPH_ENABLE, 8'h02);
        dev_op(ADDR_CORE_IRQ_CTRL, 8'hc0, 8'h01);
        chk(irq, 1'b0);
        pulse(8'h10);
        repeat (3) @(posedge ref_clk);
        #1 chk(irq, 1'b1);
        chk(irq_dev, 1'b1);
        dev_op(ADDR_CORE_IRQ_CTRL, 8'h80, 8'h01);
        chk(irq, 1'b0);
        dev_op(ADDR_CORE_IRQ_CTRL, 8'h40, 8'h01);
        chk(irq_dev, 1'b0);
        dev_op(ADDR_CORE_IRQ_CTRL, 8'hc0, 8'h01);
        dev_op(ADDR_PERIPH_FLAGS, 8'h00, 8'h01);
        chk(irq, 1'b0);
        $display("interrupt gating test done");
    endtask
    task automatic t_misc();
        pulse(8'h80);
        rdf(ADDR_RESET_CAUSE, 8'h02);
        sw_w(SW_REG_CFG, 8'h00);
        dev_op(ADDR_PERIPH_FLAGS, 8'h80, 8'h01);
        rdf(ADDR_PERIPH_FLAGS, 8'h10);
        $display("brown-out and reserved bit test done");
    endtask

    // ceiling ten times the roughly 600 cycles the tests take
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_boot();
        t_flags();
        t_ccp();
        t_live();
        t_irq();
        t_misc();
        end_sim();
    end
endmodule // tb_peripheral_irq_flags_reset_status
`default_nettype wire
